// ===== hdl/mdv_pkg.sv
// shared constants for the multichannel dma register block
package mdv_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_CH = 8;     // channels served
  localparam int TSEL_REGS = 4;  // two 5-bit selects per register
  localparam int TSEL_W = 5;     // trigger select width
  localparam int TSEL_HI = 8;    // lsb of odd channel select
  // ----------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [7:0] IDX_TSEL01 = 8'h00;
  localparam logic [7:0] IDX_TSEL23 = 8'h02;
  localparam logic [7:0] IDX_CTL2 = 8'h04;
  localparam logic [7:0] IDX_CTL3 = 8'h06;
  localparam logic [7:0] IDX_CTL4 = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h0a;  // sticky done flags
  localparam logic [7:0] IDX_MASK = 8'h0c;    // interrupt enables
  localparam logic [7:0] IDX_VECTOR = 8'h0e;
  localparam logic [7:0] IDX_CH_BASE = 8'h10; // channel n at base*(n+1)
  // offsets inside one channel group
  localparam logic [3:0] OFF_CTL = 4'h0;
  localparam logic [3:0] OFF_SRC = 4'h2;
  localparam logic [3:0] OFF_DST = 4'h6;
  localparam logic [3:0] OFF_CNT = 4'ha;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'h0007;
  localparam logic [15:0] TSEL_WMASK = 16'h1f1f;
  localparam int CTL_EN = 0;    // channel enable
  localparam int CTL_SINC = 1;  // source address steps
  localparam int CTL_DINC = 2;  // destination address steps
  localparam logic [31:0] ADDR_STEP = 32'h0000_0002;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // trigger numbers of the fixed peripheral sources
  localparam logic [4:0] TRIG_SER_RX = 5'h14;
  localparam logic [4:0] TRIG_SER_TX = 5'h15;
  localparam logic [4:0] TRIG_CONV = 5'h18;
  // vector encoding
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [31:0] RESULT_ADDR_DEF = 32'h0000_0712;
  // engine states
  typedef enum logic [1:0] {st_idle, st_read, st_write} mdv_state_e;
endpackage

// ===== hdl/mdv_conv_flag.sv
// conversion-done flag with dma trigger and auto clear
`timescale 1ns/100ps
module mdv_conv_flag (
  input logic pclk,
  input logic presetn,
  input logic conv_complete, // hardware end of conversion
  input logic sw_set,        // software writes the flag to one
  input logic dma_access,    // engine touched the result register
  output logic conversion_done_flag,
  output logic conv_trig     // one-cycle trigger to the engine
);
  // ----------------------------------------
  // flag: a set in the clear cycle wins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_complete || sw_set) begin
      conversion_done_flag <= 1'b1;
    end else if (dma_access) begin
      conversion_done_flag <= 1'b0;
    end
  end
  // only the hardware source triggers; software sets stay silent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_trig <= 1'b0;
    end else begin
      conv_trig <= conv_complete;
    end
  end
  a_sw_no_trig: assert property (@(posedge pclk) disable iff (!presetn)
    sw_set && !conv_complete |=> !conv_trig)
    else $error("software flag set raised a trigger");
  a_conv_clear: assert property (@(posedge pclk) disable iff (!presetn)
    dma_access && !conv_complete && !sw_set |=> !conversion_done_flag)
    else $error("flag not cleared by result access");
endmodule

// ===== hdl/mdv_vector.sv
// priority encoder for enabled channel done flags
`timescale 1ns/100ps
module mdv_vector #(
  parameter int NUM_CH = mdv_pkg::NUM_CH
) (
  input logic [NUM_CH-1:0] flags,
  input logic [NUM_CH-1:0] mask,
  output logic [15:0] code,          // 0 or 2(n+1)
  output logic [NUM_CH-1:0] hot      // highest enabled pending flag
);
  // ----------------------------------------
  // encoder
  // ----------------------------------------
  // walk down so channel 0 is the last to win, hence highest
  always_comb begin
    code = mdv_pkg::VEC_NONE;
    hot = '0;
    for (int n = NUM_CH - 1; n >= 0; n--) begin
      if (flags[n] && mask[n]) begin
        code = 16'(n + 1) * mdv_pkg::VEC_STEP;
        hot = '0;
        hot[n] = 1'b1;
      end
    end
  end
endmodule

// ===== hdl/mdv_top.sv
// dma register file, trigger routing, single-transfer engine, vector
`timescale 1ns/100ps
// Functional notes
// - vector 0 idle, channel n gives 2(n+1)
// - vector usable as jump table offset
// - serial module gives receive and transmit triggers
// - converter completion triggers a selected channel
// - software flag write never triggers
// - engine result access clears conversion flag
// - transfers run without processor, any mode
// - channel registers at 00h, 02h, 06h, 0Ah
// - control and vector registers reset 0000h
// - address and size registers undefined at reset
// - vector access clears highest enabled flag
// - done flag set when count reaches zero
// - channel 0 highest, disabled flags ignored
module mdv_top #(
  parameter int NUM_CH = mdv_pkg::NUM_CH,
  parameter logic [31:0] RESULT_ADDR = mdv_pkg::RESULT_ADDR_DEF
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [31:0] trig_in,       // generic peripheral triggers
  input logic serial_rx_trig,       // receive data ready
  input logic serial_tx_trig,       // transmit data needed
  input logic conv_complete,        // converter finished
  input logic conv_sw_set,          // software sets conversion flag
  output logic conversion_done_flag,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  input logic [15:0] mem_rdata,
  input logic mem_ack,
  output logic irq
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [7:0] idx;        // register index
  logic in_win;           // inside the 1 KiB window
  logic setup;            // apb setup cycle
  logic access;           // apb access cycle
  assign idx = paddr[9:2];
  assign in_win = (paddr[11:10] == 2'b00);
  assign setup = psel && !penable;
  assign access = psel && penable;
  // channel group hit, shared by read and write paths
  function automatic logic ch_hit(input logic [7:0] i);
    ch_hit = (i[7:4] != 4'h0) && (int'(i[7:4]) <= NUM_CH);
  endfunction
  function automatic logic [2:0] ch_num(input logic [7:0] i);
    logic [3:0] n;
    n = i[7:4] - 4'h1;
    ch_num = n[2:0];
  endfunction
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] tsel [mdv_pkg::TSEL_REGS]; // trigger selects
  logic [15:0] ctl4;                      // spare global control
  logic [15:0] ch_ctl [NUM_CH];           // per channel control
  logic [31:0] ch_src [NUM_CH];
  logic [31:0] ch_dst [NUM_CH];
  logic [15:0] ch_cnt [NUM_CH];
  logic [NUM_CH-1:0] flags;               // sticky done flags
  logic [NUM_CH-1:0] mask;                // interrupt enables
  logic [NUM_CH-1:0] pend;                // latched triggers
  logic [15:0] vec_code;
  logic [NUM_CH-1:0] vec_hot;
  logic [31:0] rd_val;
  logic rd_hit;
  logic err_q;
  logic [NUM_CH-1:0] rd_vec_hot;          // flag caught at setup
  logic [NUM_CH-1:0] rd_stat;             // status caught at setup
  logic wr_glb;
  logic wr_ch;
  mdv_pkg::mdv_state_e state;
  logic [2:0] act_ch;
  logic [2:0] pick;
  logic pick_any;
  logic wr_done;
  logic [15:0] cnt_left;
  logic [NUM_CH-1:0] done_set;
  logic conv_access;
  logic conv_trig;
  logic [31:0] trig_vec;
  logic [NUM_CH-1:0] trig_hit;
  logic [NUM_CH-1:0] ch_en;
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b0;
    if (in_win && ch_hit(idx)) begin
      rd_hit = 1'b1;
      case (idx[3:0])
        mdv_pkg::OFF_CTL: rd_val = 32'(ch_ctl[ch_num(idx)]);
        mdv_pkg::OFF_SRC: rd_val = ch_src[ch_num(idx)];
        mdv_pkg::OFF_DST: rd_val = ch_dst[ch_num(idx)];
        mdv_pkg::OFF_CNT: rd_val = 32'(ch_cnt[ch_num(idx)]);
        default: rd_hit = 1'b0; // gaps in the group
      endcase
    end else if (in_win) begin
      rd_hit = 1'b1;
      case (idx)
        mdv_pkg::IDX_TSEL01,
        mdv_pkg::IDX_TSEL23,
        mdv_pkg::IDX_CTL2,
        mdv_pkg::IDX_CTL3: rd_val = 32'(tsel[idx[2:1]]);
        mdv_pkg::IDX_CTL4: rd_val = 32'(ctl4);
        mdv_pkg::IDX_STATUS: rd_val = 32'(flags);
        mdv_pkg::IDX_MASK: rd_val = 32'(mask);
        mdv_pkg::IDX_VECTOR: rd_val = 32'(vec_code);
        default: rd_hit = 1'b0;
      endcase
    end
  end
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // read data is captured at setup so prdata comes from a flop;
  // the flag to clear is caught then too, so it matches the code read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      err_q <= 1'b0;
      rd_vec_hot <= '0;
      rd_stat <= '0;
    end else if (setup) begin
      prdata <= rd_val;
      err_q <= !rd_hit;
      rd_vec_hot <= (in_win && idx == mdv_pkg::IDX_VECTOR) ? vec_hot : '0;
      rd_stat <= (in_win && idx == mdv_pkg::IDX_STATUS) ? flags : '0;
    end
  end
  // zero wait states; error on unmapped indices and on addresses outside the window
  assign pready = access;
  assign pslverr = access && err_q;
  assign wr_glb = access && pwrite && rd_hit && !ch_hit(idx);
  assign wr_ch = access && pwrite && rd_hit && ch_hit(idx);
  // global control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < mdv_pkg::TSEL_REGS; r++) begin
        tsel[r] <= mdv_pkg::CTL_RESET;
      end
      ctl4 <= mdv_pkg::CTL_RESET;
      mask <= '0;
    end else if (wr_glb) begin
      case (idx)
        mdv_pkg::IDX_TSEL01,
        mdv_pkg::IDX_TSEL23,
        mdv_pkg::IDX_CTL2,
        mdv_pkg::IDX_CTL3: tsel[idx[2:1]] <= pwdata[15:0] & mdv_pkg::TSEL_WMASK;
        mdv_pkg::IDX_CTL4: ctl4 <= pwdata[15:0];
        mdv_pkg::IDX_MASK: mask <= pwdata[NUM_CH-1:0];
        default: ; // status ignores writes; vector writes only clear the highest enabled flag
      endcase
    end
  end
  // channel control; the engine drops enable at the last transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NUM_CH; n++) begin
        ch_ctl[n] <= mdv_pkg::CTL_RESET;
      end
    end else begin
      if (wr_done && cnt_left == 16'h0) begin
        ch_ctl[act_ch][mdv_pkg::CTL_EN] <= 1'b0;
      end
      if (wr_ch && idx[3:0] == mdv_pkg::OFF_CTL) begin
        ch_ctl[ch_num(idx)] <= pwdata[15:0] & mdv_pkg::CTL_WMASK;
      end
    end
  end
  // address and size carry no reset; software loads them first
  always_ff @(posedge pclk) begin
    if (wr_done) begin
      ch_cnt[act_ch] <= cnt_left;
      if (ch_ctl[act_ch][mdv_pkg::CTL_SINC]) begin
        ch_src[act_ch] <= ch_src[act_ch] + mdv_pkg::ADDR_STEP;
      end
      if (ch_ctl[act_ch][mdv_pkg::CTL_DINC]) begin
        ch_dst[act_ch] <= ch_dst[act_ch] + mdv_pkg::ADDR_STEP;
      end
    end
    if (wr_ch) begin
      case (idx[3:0])
        mdv_pkg::OFF_SRC: ch_src[ch_num(idx)] <= pwdata;
        mdv_pkg::OFF_DST: ch_dst[ch_num(idx)] <= pwdata;
        mdv_pkg::OFF_CNT: ch_cnt[ch_num(idx)] <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // trigger routing
  // ----------------------------------------
  always_comb begin
    trig_vec = trig_in;
    trig_vec[mdv_pkg::TRIG_SER_RX] = serial_rx_trig;
    trig_vec[mdv_pkg::TRIG_SER_TX] = serial_tx_trig;
    trig_vec[mdv_pkg::TRIG_CONV] = conv_trig;
  end
  // each channel picks its source through its 5-bit select field
  for (genvar g = 0; g < NUM_CH; g++) begin : g_trig
    logic [4:0] sel;
    assign sel = tsel[g / 2][(g % 2) * mdv_pkg::TSEL_HI +: mdv_pkg::TSEL_W];
    assign ch_en[g] = ch_ctl[g][mdv_pkg::CTL_EN];
    assign trig_hit[g] = ch_en[g] && trig_vec[sel];
  end
  // a new trigger wins over the grab of the same channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (trig_hit[n]) begin
          pend[n] <= 1'b1;
        end else if (!ch_en[n] || (state == mdv_pkg::st_idle && pick_any
                     && pick == 3'(n))) begin
          pend[n] <= 1'b0;
        end
      end
    end
  end
  // fixed priority among pending channels, channel 0 first
  always_comb begin
    pick = 3'h0;
    pick_any = 1'b0;
    for (int n = NUM_CH - 1; n >= 0; n--) begin
      if (pend[n]) begin
        pick = 3'(n);
        pick_any = 1'b1;
      end
    end
  end
  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  // runs on its own; no processor handshake or power-mode gate,
  // so a halted processor never stalls data movement
  assign wr_done = (state == mdv_pkg::st_write) && mem_ack;
  assign cnt_left = ch_cnt[act_ch] - mdv_pkg::CNT_ONE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mdv_pkg::st_idle;
      act_ch <= 3'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 16'h0;
    end else begin
      unique case (state)
        mdv_pkg::st_idle: begin
          if (pick_any) begin
            state <= mdv_pkg::st_read;
            act_ch <= pick;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= ch_src[pick];
          end
        end
        mdv_pkg::st_read: begin
          if (mem_ack) begin
            state <= mdv_pkg::st_write;
            mem_we <= 1'b1;
            mem_addr <= ch_dst[act_ch];
            mem_wdata <= mem_rdata;
          end
        end
        mdv_pkg::st_write: begin
          if (mem_ack) begin
            state <= mdv_pkg::st_idle;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
          end
        end
      endcase
    end
  end
  // a completed read of the result register clears its flag
  assign conv_access = (state == mdv_pkg::st_read) && mem_ack
                       && mem_addr == RESULT_ADDR;
  mdv_conv_flag u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .conv_complete(conv_complete),
    .sw_set(conv_sw_set),
    .dma_access(conv_access),
    .conversion_done_flag(conversion_done_flag),
    .conv_trig(conv_trig)
  );
  // ----------------------------------------
  // done flags, vector and interrupt
  // ----------------------------------------
  always_comb begin
    done_set = '0;
    if (wr_done && cnt_left == 16'h0) begin
      done_set[act_ch] = 1'b1;
    end
  end
  // set wins over both vector-access and status-read clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~((access ? rd_vec_hot : '0)
               | ((access && !pwrite) ? rd_stat : '0))) | done_set;
    end
  end
  mdv_vector #(.NUM_CH(NUM_CH)) u_vec (
    .flags(flags),
    .mask(mask),
    .code(vec_code),
    .hot(vec_hot)
  );
  assign irq = |(flags & mask);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_read_done;
    state == mdv_pkg::st_read && mem_ack;
  endsequence
  sequence s_conv_trig;
    conv_complete ##1 (conv_trig && ch_en[0]
      && tsel[0][mdv_pkg::TSEL_W-1:0] == mdv_pkg::TRIG_CONV);
  endsequence
  a_vec_idle: assert property ((flags & mask) == '0 |-> vec_code == 16'h0)
    else $error("vector nonzero with nothing pending");
  a_vec_top: assert property (flags[0] && mask[0] |-> vec_code == 16'h2)
    else $error("channel 0 not given top priority");
  a_vec_offset: assert property (!vec_code[0] && vec_code <= 16'h10)
    else $error("vector not an even table offset");
  // channel 1 is the one the bench routes to the receive trigger
  a_trig_serial: assert property (serial_rx_trig && ch_en[1]
    && tsel[0][mdv_pkg::TSEL_HI +: mdv_pkg::TSEL_W] == mdv_pkg::TRIG_SER_RX |=> pend[1])
    else $error("serial receive trigger lost");
  a_trig_conv: assert property (s_conv_trig |=> pend[0])
    else $error("conversion did not start transfer");
  a_engine_step: assert property (s_read_done |=> state == mdv_pkg::st_write
    && mem_req && mem_we)
    else $error("write did not follow read");
  a_vec_clear: assert property (access && rd_vec_hot != '0
    && (done_set & rd_vec_hot) == '0 |=> (flags & $past(rd_vec_hot)) == '0)
    else $error("vector access did not clear flag");
  a_done_set: assert property (wr_done && ch_cnt[act_ch] == 16'h1
    |=> flags[$past(act_ch)] && !ch_en[$past(act_ch)])
    else $error("done flag missing at zero count");
  a_irq_vec: assert property (irq == (vec_code != 16'h0))
    else $error("interrupt disagrees with vector");
  // channel 1 group sits at index 0x20, so its count is byte 0x0a8
  a_cnt_read: assert property (setup && !pwrite && paddr == 12'h0a8
    |=> prdata == 32'($past(ch_cnt[1])))
    else $error("channel count read wrong");
endmodule

// ===== verif/mdv_mem_model.sv
// memory-bus partner model that answers the engine's word requests
`timescale 1ns/100ps
module mdv_mem_model (
  input logic pclk,
  input logic presetn,
  input logic mem_req,
  input logic mem_we,
  input logic [31:0] mem_addr,
  input logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  input logic [3:0] ack_delay,   // extra wait cycles per phase
  output logic [31:0] last_addr, // last written address
  output logic [15:0] last_data, // last written word
  output int wr_cnt              // writes seen so far
);
  logic [3:0] wait_cnt; // cycles waited in this phase
  logic toggle;         // filler so stale data never looks valid
  // --------------------------------
  // answer logic
  // --------------------------------
  // one ack pulse per phase, wait restarts for the next phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      toggle <= 1'b0;
      wr_cnt <= 0;
    end else begin
      toggle <= ~toggle;
      if (mem_ack) begin
        mem_ack <= 1'b0;
        wait_cnt <= 4'h0;
        if (mem_req && mem_we) begin // no processor in the loop
          last_addr <= mem_addr;
          last_data <= mem_wdata;
          wr_cnt <= wr_cnt + 1;
        end
      end else if (mem_req) begin
        if (wait_cnt >= ack_delay) begin
          mem_ack <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
  // read word derived from the address, changing pattern otherwise
  assign mem_rdata = mem_ack ? (mem_addr[15:0] ^ 16'h5a5a) : {16{toggle}};
endmodule

// ===== verif/multichannel_dma_regs_vector_test.sv
// self-checking bench for the dma register, trigger and vector block
`timescale 1ns/100ps
module multichannel_dma_regs_vector_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trig_in, mem_addr, last_addr;
  logic serial_rx_trig, serial_tx_trig, conv_complete, conv_sw_set;
  logic conversion_done_flag, mem_req, mem_we, mem_ack, irq;
  logic [15:0] mem_wdata, mem_rdata, last_data;
  logic [3:0] ack_delay;
  logic [31:0] rd;
  logic er;
  int wr_cnt, miscompares, cmp_count, cycles;
  // --------------------------------
  // design and memory partner
  // --------------------------------
  mdv_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .serial_rx_trig(serial_rx_trig),
    .serial_tx_trig(serial_tx_trig), .conv_complete(conv_complete),
    .conv_sw_set(conv_sw_set), .conversion_done_flag(conversion_done_flag),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
  mdv_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .ack_delay(ack_delay), .last_addr(last_addr), .last_data(last_data), .wr_cnt(wr_cnt));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] gla(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  // channel groups sit at index 0x10*(n+1)
  function automatic logic [11:0] cha(input int ch, input logic [3:0] off);
    logic [7:0] idx;
    idx = mdv_pkg::IDX_CH_BASE * 8'(ch + 1) + {4'h0, off};
    return {2'b00, idx, 2'b00};
  endfunction
  // one-word transfer setup: select, addresses, count one, enable
  task automatic prog(input int ch, input logic [4:0] sel, input logic [31:0] src);
    logic [31:0] v;
    v = (ch % 2) ? {19'h0, sel, 8'h00} : {27'h0, sel};
    apb(1'b1, gla(mdv_pkg::IDX_TSEL01 + 8'(2 * (ch / 2))), v);
    apb(1'b1, cha(ch, mdv_pkg::OFF_SRC), src);
    apb(1'b1, cha(ch, mdv_pkg::OFF_DST), 32'h0000_2000 + 32'(ch * 2));
    apb(1'b1, cha(ch, mdv_pkg::OFF_CNT), 32'h0000_0001);
    apb(1'b1, cha(ch, mdv_pkg::OFF_CTL), 32'h0000_0001);
  endtask
  // wait for the write phase, then judge the moved word
  task automatic xfer(input int ch, input logic [31:0] src);
    int n0;
    n0 = wr_cnt;
    for (int i = 0; i < 64 && wr_cnt == n0; i++) @(posedge pclk);
    check(last_addr, 32'h0000_2000 + 32'(ch * 2), "dest address");
    check({16'h0, last_data}, {16'h0, src[15:0] ^ 16'h5a5a}, "moved word");
    repeat (3) @(posedge pclk);
  endtask
  task automatic vec(input logic [15:0] exp);
    apb(1'b0, gla(mdv_pkg::IDX_VECTOR), 32'h0);
    check(rd, {16'h0, exp}, "vector code");
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  // reset values, channel offsets, refused addresses
  task automatic t_reset();
    logic [7:0] gl [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0e};
    foreach (gl[i]) begin
      apb(1'b0, gla(gl[i]), 32'h0);
      check(rd, 32'h0, "global reset value");
    end
    for (int c = 0; c < 8; c++) begin
      apb(1'b0, cha(c, mdv_pkg::OFF_CTL), 32'h0);
      check(rd, 32'h0, "channel control reset");
    end
    apb(1'b1, cha(6, mdv_pkg::OFF_SRC), 32'h1234_5678);
    apb(1'b0, cha(6, mdv_pkg::OFF_SRC), 32'h0);
    check(rd, 32'h1234_5678, "source readback");
    apb(1'b1, cha(6, mdv_pkg::OFF_CNT), 32'h0000_00a5);
    apb(1'b0, cha(6, mdv_pkg::OFF_CNT), 32'h0);
    check(rd, 32'h0000_00a5, "count readback");
    apb(1'b0, cha(6, 4'h4), 32'h0);
    check({31'h0, er}, 32'h1, "gap offset refused");
    apb(1'b0, 12'hc00, 32'h0);
    check({31'h0, er}, 32'h1, "high address refused");
  endtask
  // every channel gives its own code; access clears it
  task automatic t_vector();
    apb(1'b1, gla(mdv_pkg::IDX_MASK), 32'h0000_00ff);
    for (int c = 0; c < 8; c++) begin
      ack_delay <= (c % 2) ? 4'h3 : 4'h0; // slow answers on odd channels
      prog(c, 5'(c), 32'h0000_0100 + 32'(c * 16));
      @(posedge pclk);
      trig_in[c] <= 1'b1;
      @(posedge pclk);
      trig_in <= 32'h0;
      xfer(c, 32'h0000_0100 + 32'(c * 16));
      check({31'h0, irq}, 32'h1, "irq raised");
      vec(16'(2 * (c + 1)));
      @(posedge pclk); // the clear lands at the access edge
      check({31'h0, irq}, 32'h0, "irq dropped");
      vec(mdv_pkg::VEC_NONE);
    end
  endtask
  // disabled flags ignored, channel 2 ahead of 5, write clears too
  task automatic t_priority();
    apb(1'b1, gla(mdv_pkg::IDX_MASK), 32'h0);
    prog(5, 5'h05, 32'h0000_0300);
    trig_in[5] <= 1'b1;
    @(posedge pclk);
    trig_in <= 32'h0;
    xfer(5, 32'h0000_0300);
    prog(2, 5'h02, 32'h0000_0400);
    trig_in[2] <= 1'b1;
    @(posedge pclk);
    trig_in <= 32'h0;
    xfer(2, 32'h0000_0400);
    check({31'h0, irq}, 32'h0, "masked flags quiet");
    vec(mdv_pkg::VEC_NONE);
    apb(1'b1, gla(mdv_pkg::IDX_MASK), 32'h0000_00ff);
    vec(16'h0006);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1, "second flag still asks");
    apb(1'b1, gla(mdv_pkg::IDX_VECTOR), 32'h0);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0, "write cleared last flag");
  endtask
  // receive and transmit triggers of the serial module
  task automatic t_serial();
    prog(1, mdv_pkg::TRIG_SER_RX, 32'h0000_0500);
    serial_rx_trig <= 1'b1;
    @(posedge pclk);
    serial_rx_trig <= 1'b0;
    xfer(1, 32'h0000_0500);
    apb(1'b0, cha(1, mdv_pkg::OFF_CNT), 32'h0);
    check(rd, 32'h0, "count ran to zero");
    prog(3, mdv_pkg::TRIG_SER_TX, 32'h0000_0600);
    serial_tx_trig <= 1'b1;
    @(posedge pclk);
    serial_tx_trig <= 1'b0;
    xfer(3, 32'h0000_0600);
    vec(16'h0004);
    vec(16'h0008);
  endtask
  // software set never triggers; completion does and is cleared
  task automatic t_conv();
    int n0;
    prog(0, mdv_pkg::TRIG_CONV, mdv_pkg::RESULT_ADDR_DEF);
    n0 = wr_cnt;
    conv_sw_set <= 1'b1;
    @(posedge pclk);
    conv_sw_set <= 1'b0;
    repeat (12) @(posedge pclk);
    check(32'(wr_cnt), 32'(n0), "software set moved data");
    check({31'h0, conversion_done_flag}, 32'h1, "flag set by software");
    conv_complete <= 1'b1;
    @(posedge pclk);
    conv_complete <= 1'b0;
    xfer(0, mdv_pkg::RESULT_ADDR_DEF);
    check({31'h0, conversion_done_flag}, 32'h0, "flag auto cleared");
    vec(16'h0002);
    // second conversion: the status register shows the flag and a read clears it
    prog(0, mdv_pkg::TRIG_CONV, mdv_pkg::RESULT_ADDR_DEF);
    conv_complete <= 1'b1;
    @(posedge pclk);
    conv_complete <= 1'b0;
    xfer(0, mdv_pkg::RESULT_ADDR_DEF);
    apb(1'b0, gla(mdv_pkg::IDX_STATUS), 32'h0);
    check(rd, 32'h1, "status shows done flag");
    apb(1'b0, gla(mdv_pkg::IDX_STATUS), 32'h0);
    check(rd, 32'h0, "status read cleared flag");
    check({31'h0, irq}, 32'h0, "irq quiet after status read");
  endtask
  // --------------------------------
  // clock, timeout, main sequence
  // --------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // run is well under 5000 cycles, so this only cuts a hang
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, serial_rx_trig, serial_tx_trig} = 5'h00;
    {conv_complete, conv_sw_set} = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig_in = 32'h0;
    ack_delay = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_vector();
    t_priority();
    t_serial();
    t_conv();
    give_verdict();
  end
endmodule
